//--- design/sspr_slave.sv
// slave end: subscriber filter table, setpoint routing, publisher answer, faults, diagnostics
`timescale 1ns/1ps
`default_nettype none
module sspr_slave #(
  parameter int unsigned LINK_TMO = sspr_pkg::LINK_TMO_CYC,
  parameter int unsigned MST_TMO = sspr_pkg::MST_TMO_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  sspr_bus_if.dev bus,
  input wire logic [sspr_pkg::SP_WORDS-1:0][15:0] act_words_i,
  output logic [sspr_pkg::SP_WORDS-1:0][15:0] sp_words_o,
  output logic subscriber_o,
  output logic prm_err_o,
  output logic cfg_err_o,
  output logic [sspr_pkg::MAX_LINKS-1:0] pub_len_err_o,
  output logic publisher_link_lost_alarm_o,
  output logic [sspr_pkg::MAX_LINKS-1:0] publisher_link_lost_fault_o,
  output logic master_cyclic_loss_alarm_o,
  output logic master_cyclic_loss_fault_o,
  output logic [sspr_pkg::SP_WORDS-1:0][7:0] rx_word_source_address_diag_o,
  output logic [sspr_pkg::SP_WORDS-1:0][7:0] rx_word_offset_diag_o,
  output logic [sspr_pkg::SP_WORDS-1:0][7:0] tx_word_offset_diag_o
);
  localparam int NL = sspr_pkg::MAX_LINKS;
  localparam int NT = sspr_pkg::N_TAPS;
  localparam int NW = sspr_pkg::SP_WORDS;

  typedef enum logic [1:0] {
    SSPR_TX_IDLE = 2'b01,
    SSPR_TX_SEND = 2'b10
  } sspr_tx_t;

  typedef struct packed {
    sspr_tx_t tx;
    logic [4:0] tx_idx;
    logic tx_bcast;
    logic [7:0] idx;
    logic [sspr_pkg::FILT_BYTES-1:0][7:0] filt;
    logic hdr_ok;
    logic subscr;
    logic prm_err;
    logic cfg_err;
    logic [3:0] n_sp;
    logic [3:0] n_act;
    logic [7:0] n_tapid;
    logic [sspr_pkg::SP_BYTES-1:0][7:0] sp;
    logic [sspr_pkg::SP_BYTES-1:0][7:0] shadow;
    logic [6:0] mst_addr;
    logic mst_seen;
    logic [sspr_pkg::TMO_W-1:0] mst_cnt;
    logic mst_lost;
    logic mst_fault;
    logic [NL-1:0][sspr_pkg::TMO_W-1:0] lk_cnt;
    logic [NL-1:0] lk_lost;
    logic [NL-1:0] lk_fault;
    logic [NL-1:0] len_err;
    logic pl_alarm;
    logic rs_valid;
    logic rs_last;
    logic rs_bcast;
    logic [7:0] rs_byte;
    logic [NW-1:0][7:0] diag_src;
    logic [NW-1:0][7:0] diag_rx;
    logic [NW-1:0][7:0] diag_tx;
  } sspr_slv_q_t;

  sspr_slv_q_t q;
  sspr_slv_q_t d;

  // filter table decode; offsets count from the block start, the only version accepted
  logic [NL-1:0] lk_ok;
  logic [NL-1:0][6:0] lk_addr;
  logic [NL-1:0][7:0] lk_inlen;
  logic [NL-1:0][7:0] lk_ofs;
  logic [NL-1:0][7:0] lk_end;
  logic [NT-1:0] tp_ok;
  logic [NT-1:0][7:0] tp_src;
  logic [NT-1:0][7:0] tp_dst;
  logic [NT-1:0][7:0] tp_len;

  for (genvar l = 0; l < NL; l++) begin : g_link
    assign lk_ofs[l] = q.filt[sspr_pkg::FB_POS_OFS0 + l];
    assign lk_end[l] = (8'(l + 1) < q.filt[sspr_pkg::FB_POS_NLINK]) ?
                       q.filt[sspr_pkg::FB_POS_OFS0 + l + 1] : q.filt[sspr_pkg::FB_POS_LEN];
    assign lk_ok[l] = q.subscr && (8'(l) < q.filt[sspr_pkg::FB_POS_NLINK]);
    assign lk_addr[l] = q.filt[lk_ofs[l][4:0]][6:0];
    assign lk_inlen[l] = q.filt[5'(lk_ofs[l][4:0] + 5'(sspr_pkg::LK_POS_INLEN))];
  end

  for (genvar t = 0; t < NT; t++) begin : g_tap
    localparam int L = t / sspr_pkg::TAPS_PER_LINK;
    localparam int TOFS = sspr_pkg::LK_POS_TAP0 + sspr_pkg::TAP_BYTES * (t % sspr_pkg::TAPS_PER_LINK);
    logic [8:0] base;
    logic [8:0] top;
    assign base = 9'(lk_ofs[L]) + 9'(TOFS);
    assign top = base + 9'(sspr_pkg::TAP_BYTES);
    // a tap must sit wholly inside its link and inside the kept table
    assign tp_ok[t] = lk_ok[L] && (top <= 9'(lk_end[L])) && (top <= 9'(sspr_pkg::FILT_BYTES));
    assign tp_src[t] = q.filt[base[4:0]];
    assign tp_dst[t] = q.filt[5'(base + 9'(sspr_pkg::TP_POS_DST))];
    assign tp_len[t] = q.filt[5'(base + 9'(sspr_pkg::TP_POS_LEN))];
  end

  always_comb begin
    logic [7:0] pos;
    logic [7:0] b;
    logic hdr;
    logic [7:0] bl;
    logic [7:0] ntap;
    logic [8:0] tgt;
    logic [8:0] w2;
    logic hit;
    logic bad;
    logic [sspr_pkg::SP_BYTES-1:0][7:0] sh;
    pos = bus.fr_sof ? 8'h00 : q.idx;
    b = bus.fr_byte;
    hdr = 1'b1;
    bl = 8'h00;
    ntap = 8'h00;
    tgt = 9'h000;
    w2 = 9'h000;
    hit = 1'b0;
    bad = 1'b0;
    sh = bus.fr_sof ? q.sp : q.shadow;
    d = q;
    d.rs_valid = 1'b0;
    d.rs_last = 1'b0;
    for (int t = 0; t < NT; t++) begin
      ntap = ntap + 8'(tp_ok[t]);
    end

    // silence watchdogs; isochronous sign of life is not watched
    for (int l = 0; l < NL; l++) begin
      if (lk_ok[l]) begin
        if (q.lk_cnt[l] >= sspr_pkg::TMO_W'(LINK_TMO)) begin
          d.lk_lost[l] = 1'b1;
          d.lk_fault[l] = 1'b1;
        end else begin
          d.lk_cnt[l] = q.lk_cnt[l] + 1'b1;
        end
      end
    end
    if (q.mst_seen) begin
      if (q.mst_cnt >= sspr_pkg::TMO_W'(MST_TMO)) begin
        d.mst_lost = 1'b1;
        d.mst_fault = 1'b1;
      end else begin
        d.mst_cnt = q.mst_cnt + 1'b1;
      end
    end

    // answer to a data exchange, high byte of each word first
    case (q.tx)
      SSPR_TX_IDLE: d.tx = SSPR_TX_IDLE;
      SSPR_TX_SEND: begin
        d.rs_valid = 1'b1;
        d.rs_bcast = q.tx_bcast;
        d.rs_byte = q.tx_idx[0] ? act_words_i[q.tx_idx[3:1]][7:0] :
                    act_words_i[q.tx_idx[3:1]][15:8];
        d.tx_idx = q.tx_idx + 5'h01;
        if (q.tx_idx == {q.n_act, 1'b0} - 5'h01) begin
          d.rs_last = 1'b1;
          d.tx = SSPR_TX_IDLE;
        end
      end
      default: d.tx = SSPR_TX_IDLE;
    endcase

    if (bus.fr_valid) begin
      d.idx = pos + 8'h01;
      case (bus.fr_kind)
        sspr_pkg::SSPR_FK_PRM: begin
          if (pos < 8'(sspr_pkg::FILT_BYTES)) d.filt[pos[4:0]] = b;
          case (pos)
            sspr_pkg::FB_POS_LEN: hdr = (b >= sspr_pkg::FB_LEN_MIN) && (b <= sspr_pkg::FB_LEN_MAX);
            sspr_pkg::FB_POS_CMD: hdr = (b == sspr_pkg::FB_CMD);
            sspr_pkg::FB_POS_SLOT: hdr = (b == sspr_pkg::FB_SLOT);
            sspr_pkg::FB_POS_SPEC: hdr = (b == sspr_pkg::FB_SPEC);
            sspr_pkg::FB_POS_VER: hdr = (b == sspr_pkg::FB_VER);
            sspr_pkg::FB_POS_NLINK: hdr = (b <= sspr_pkg::FB_LINKS_MAX);
            default: hdr = 1'b1;
          endcase
          d.hdr_ok = (bus.fr_sof || q.hdr_ok) && hdr;
          if (bus.fr_eof) begin
            bl = bus.fr_sof ? b : q.filt[sspr_pkg::FB_POS_LEN];
            d.prm_err = 1'b0;
            if (bl == 8'h00) begin
              d.subscr = 1'b0;
            end else if (d.hdr_ok && pos >= bl - 8'h01) begin
              d.subscr = 1'b1;
            end else begin
              d.subscr = 1'b0;
              d.prm_err = 1'b1;
            end
            // a new bus start clears every monitor
            d.lk_cnt = '0;
            d.lk_lost = '0;
            d.lk_fault = '0;
            d.len_err = '0;
            d.mst_seen = 1'b0;
            d.mst_cnt = '0;
            d.mst_lost = 1'b0;
            d.mst_fault = 1'b0;
            d.mst_addr = bus.fr_src;
          end
        end
        sspr_pkg::SSPR_FK_CFG: begin
          if (pos == sspr_pkg::CFG_POS_SP) begin
            d.n_sp = (b > 8'(sspr_pkg::WORDS_MAX)) ? sspr_pkg::WORDS_MAX : b[3:0];
            d.n_tapid = 8'h00;
          end else if (pos == sspr_pkg::CFG_POS_ACT) begin
            d.n_act = (b > 8'(sspr_pkg::WORDS_MAX)) ? sspr_pkg::WORDS_MAX : b[3:0];
          end else if (b == sspr_pkg::CFG_TAP_ID) begin
            d.n_tapid = q.n_tapid + 8'h01;
          end
          if (bus.fr_eof) begin
            d.cfg_err = q.subscr && (d.n_tapid != ntap);
            for (int t = 0; t < NT; t++) begin
              if (tp_ok[t] && tp_dst[t] < {3'b000, d.n_sp, 1'b0}) d.cfg_err = 1'b1;
            end
          end
        end
        sspr_pkg::SSPR_FK_DX, sspr_pkg::SSPR_FK_DXB: begin
          // master part only; extension bytes belong to publishers
          if (pos < {3'b000, q.n_sp, 1'b0}) d.sp[pos[3:0]] = b;
          d.mst_seen = 1'b1;
          d.mst_cnt = '0;
          d.mst_lost = 1'b0;
          d.mst_addr = bus.fr_src;
          if (bus.fr_eof && q.n_act != 4'h0) begin
            d.tx = SSPR_TX_SEND;
            d.tx_idx = 5'h00;
            d.tx_bcast = (bus.fr_kind == sspr_pkg::SSPR_FK_DXB);
          end
        end
        sspr_pkg::SSPR_FK_BCAST: begin
          // staged copy, so a short or long frame never touches live setpoints
          for (int t = 0; t < NT; t++) begin
            if (tp_ok[t] && lk_addr[t / sspr_pkg::TAPS_PER_LINK] == bus.fr_src &&
                pos >= tp_src[t] && (pos - tp_src[t]) < tp_len[t]) begin
              tgt = 9'(tp_dst[t]) + 9'(pos - tp_src[t]);
              if (tgt < 9'(sspr_pkg::SP_BYTES)) sh[tgt[3:0]] = b;
            end
          end
          d.shadow = sh;
          if (bus.fr_eof) begin
            for (int l = 0; l < NL; l++) begin
              if (lk_ok[l] && lk_addr[l] == bus.fr_src) begin
                hit = 1'b1;
                if (lk_inlen[l] != pos + 8'h01) begin
                  bad = 1'b1;
                  d.len_err[l] = 1'b1;
                end else begin
                  d.lk_cnt[l] = '0;
                  d.lk_lost[l] = 1'b0;
                end
              end
            end
            if (hit && !bad) d.sp = sh;
          end
        end
        default: d.idx = pos + 8'h01;
      endcase
    end
    d.pl_alarm = |d.lk_lost;

    for (int w = 0; w < NW; w++) begin
      w2 = 9'(2 * w);
      d.diag_src[w] = sspr_pkg::DIAG_NONE;
      d.diag_rx[w] = sspr_pkg::DIAG_NONE;
      d.diag_tx[w] = (4'(w) < q.n_act) ? w2[7:0] : sspr_pkg::DIAG_NONE;
      if (4'(w) < q.n_sp) begin
        d.diag_src[w] = {1'b0, q.mst_addr};
        d.diag_rx[w] = w2[7:0];
      end else begin
        for (int t = 0; t < NT; t++) begin
          if (tp_ok[t] && 9'(tp_dst[t]) <= w2 && w2 < 9'(tp_dst[t]) + 9'(tp_len[t])) begin
            d.diag_src[w] = {1'b0, lk_addr[t / sspr_pkg::TAPS_PER_LINK]};
            d.diag_rx[w] = w2[7:0];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.tx <= SSPR_TX_IDLE;
      q.diag_src <= {NW{sspr_pkg::DIAG_NONE}};
      q.diag_rx <= {NW{sspr_pkg::DIAG_NONE}};
      q.diag_tx <= {NW{sspr_pkg::DIAG_NONE}};
    end else begin
      q <= d;
    end
  end

  for (genvar w = 0; w < NW; w++) begin : g_word
    assign sp_words_o[w] = {q.sp[2 * w], q.sp[2 * w + 1]};
  end
  assign bus.rs_valid = q.rs_valid;
  assign bus.rs_last = q.rs_last;
  assign bus.rs_bcast = q.rs_bcast;
  assign bus.rs_byte = q.rs_byte;
  assign subscriber_o = q.subscr;
  assign prm_err_o = q.prm_err;
  assign cfg_err_o = q.cfg_err;
  assign pub_len_err_o = q.len_err;
  assign publisher_link_lost_alarm_o = q.pl_alarm;
  assign publisher_link_lost_fault_o = q.lk_fault;
  assign master_cyclic_loss_alarm_o = q.mst_lost;
  assign master_cyclic_loss_fault_o = q.mst_fault;
  assign rx_word_source_address_diag_o = q.diag_src;
  assign rx_word_offset_diag_o = q.diag_rx;
  assign tx_word_offset_diag_o = q.diag_tx;
endmodule : sspr_slave
`default_nettype wire

//--- include/sspr_pkg.sv
// constants and types shared by both ends of the slave-to-slave setpoint router
package sspr_pkg;
  localparam int SP_WORDS = 8;
  localparam int SP_BYTES = 16;
  localparam int FILT_BYTES = 32;
  localparam int MAX_LINKS = 3;
  localparam int TAPS_PER_LINK = 2;
  localparam int N_TAPS = 6;
  localparam int TMO_W = 20;
  // filter block header values
  localparam logic [7:0] FB_LEN_MIN = 8'h0c;
  localparam logic [7:0] FB_LEN_MAX = 8'hf4;
  localparam logic [7:0] FB_CMD = 8'he2;
  localparam logic [7:0] FB_SLOT = 8'h00;
  localparam logic [7:0] FB_SPEC = 8'h00;
  localparam logic [7:0] FB_VER = 8'he2;
  localparam logic [7:0] FB_LINKS_MAX = 8'h03;
  // byte positions inside the filter block, a link entry and a tap entry
  localparam logic [7:0] FB_POS_LEN = 8'h00;
  localparam logic [7:0] FB_POS_CMD = 8'h01;
  localparam logic [7:0] FB_POS_SLOT = 8'h02;
  localparam logic [7:0] FB_POS_SPEC = 8'h03;
  localparam logic [7:0] FB_POS_VER = 8'h04;
  localparam logic [7:0] FB_POS_NLINK = 8'h05;
  localparam int FB_POS_OFS0 = 6;
  localparam int LK_POS_INLEN = 1;
  localparam int LK_POS_TAP0 = 2;
  localparam int TAP_BYTES = 3;
  localparam int TP_POS_DST = 1;
  localparam int TP_POS_LEN = 2;
  // configuration frame layout, word-count limit and diagnostic filler value
  localparam logic [7:0] CFG_POS_SP = 8'h00;
  localparam logic [7:0] CFG_POS_ACT = 8'h01;
  localparam logic [7:0] CFG_TAP_ID = 8'hc1;
  localparam logic [7:0] DIAG_NONE = 8'hff;
  localparam logic [3:0] WORDS_MAX = 4'h8;
  // timing
  localparam int CLK_KHZ = 40000;
  localparam int LINK_TMO_US = 10000;
  localparam int MST_TMO_US = 10000;
  localparam int RSP_TMO_US = 10;
  localparam int LINK_TMO_CYC = LINK_TMO_US * CLK_KHZ / 1000;
  localparam int MST_TMO_CYC = MST_TMO_US * CLK_KHZ / 1000;
  localparam int RSP_TMO_CYC = RSP_TMO_US * CLK_KHZ / 1000;

  typedef enum logic [4:0] {
    SSPR_FK_PRM = 5'b00001,
    SSPR_FK_CFG = 5'b00010,
    SSPR_FK_DX = 5'b00100,
    SSPR_FK_DXB = 5'b01000,
    SSPR_FK_BCAST = 5'b10000
  } sspr_kind_t;
endpackage : sspr_pkg

//--- include/sspr_bus_if.sv
// byte-stream fieldbus link between the master side and a slave
`timescale 1ns/1ps
`default_nettype none
interface sspr_bus_if (
  input wire logic clk_sys_i,
  input wire logic rst_b_i
);
  logic fr_valid;
  logic fr_sof;
  logic fr_eof;
  logic [7:0] fr_byte;
  logic [6:0] fr_src;
  sspr_pkg::sspr_kind_t fr_kind;
  logic rs_valid;
  logic rs_last;
  logic rs_bcast;
  logic [7:0] rs_byte;

  modport dev (
    input fr_valid, fr_sof, fr_eof, fr_byte, fr_src, fr_kind,
    output rs_valid, rs_last, rs_bcast, rs_byte
  );
  modport mst (
    output fr_valid, fr_sof, fr_eof, fr_byte, fr_src, fr_kind,
    input rs_valid, rs_last, rs_bcast, rs_byte
  );
endinterface : sspr_bus_if
`default_nettype wire

//--- design/sspr_master.sv
// master end: sends parameter, configuration, data and peer broadcast frames
`timescale 1ns/1ps
`default_nettype none
module sspr_master (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  sspr_bus_if.mst bus,
  input wire logic req_valid_i,
  input wire sspr_pkg::sspr_kind_t req_kind_i,
  input wire logic [6:0] req_src_i,
  input wire logic [5:0] req_len_i,
  input wire logic [sspr_pkg::FILT_BYTES-1:0][7:0] req_data_i,
  output logic busy_o,
  output logic done_o,
  output logic rsp_tmo_o,
  output logic rsp_bcast_o,
  output logic [4:0] rsp_len_o,
  output logic [sspr_pkg::SP_BYTES-1:0][7:0] rsp_data_o
);
  typedef enum logic [2:0] {
    SSPR_M_IDLE = 3'b001,
    SSPR_M_SEND = 3'b010,
    SSPR_M_WAIT = 3'b100
  } sspr_mst_st_t;

  typedef struct packed {
    sspr_mst_st_t st;
    sspr_pkg::sspr_kind_t kind;
    logic [6:0] src;
    logic [5:0] len;
    logic [5:0] idx;
    logic [sspr_pkg::FILT_BYTES-1:0][7:0] data;
    logic fr_valid;
    logic fr_sof;
    logic fr_eof;
    logic [7:0] fr_byte;
    logic busy;
    logic done;
    logic tmo;
    logic bcast;
    logic [4:0] rlen;
    logic [15:0] wcnt;
    logic [sspr_pkg::SP_BYTES-1:0][7:0] rdata;
  } sspr_mst_q_t;

  sspr_mst_q_t q;
  sspr_mst_q_t d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.fr_valid = 1'b0;
    d.fr_sof = 1'b0;
    d.fr_eof = 1'b0;
    case (q.st)
      SSPR_M_IDLE: begin
        // a zero or oversize length is silently refused
        if (req_valid_i && req_len_i != 6'h00 && req_len_i <= 6'(sspr_pkg::FILT_BYTES)) begin
          d.st = SSPR_M_SEND;
          d.kind = req_kind_i;
          d.src = req_src_i;
          d.len = req_len_i;
          d.data = req_data_i;
          d.idx = 6'h00;
          d.busy = 1'b1;
        end
      end
      SSPR_M_SEND: begin
        // word counts, tap ids and filter block go out as the caller built them
        d.fr_valid = 1'b1;
        d.fr_sof = (q.idx == 6'h00);
        d.fr_eof = (q.idx == q.len - 6'h01);
        d.fr_byte = q.data[q.idx[4:0]];
        d.idx = q.idx + 6'h01;
        if (q.idx == q.len - 6'h01) begin
          if (q.kind == sspr_pkg::SSPR_FK_DX || q.kind == sspr_pkg::SSPR_FK_DXB) begin
            d.st = SSPR_M_WAIT;
            d.wcnt = 16'h0000;
            d.rlen = 5'h00;
            d.tmo = 1'b0;
            d.bcast = 1'b0;
          end else begin
            d.st = SSPR_M_IDLE;
            d.busy = 1'b0;
            d.done = 1'b1;
          end
        end
      end
      SSPR_M_WAIT: begin
        d.wcnt = q.wcnt + 16'h0001;
        if (bus.rs_valid) begin
          if (q.rlen < 5'(sspr_pkg::SP_BYTES)) begin
            d.rdata[q.rlen[3:0]] = bus.rs_byte;
            d.rlen = q.rlen + 5'h01;
          end
          // a publisher addressed with the broadcast request answers flagged
          d.bcast = bus.rs_bcast && (q.kind == sspr_pkg::SSPR_FK_DXB);
        end
        if (bus.rs_valid && bus.rs_last) begin
          d.st = SSPR_M_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
        end else if (q.wcnt >= 16'(sspr_pkg::RSP_TMO_CYC)) begin
          d.st = SSPR_M_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.tmo = 1'b1;
        end
      end
      default: d.st = SSPR_M_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.st <= SSPR_M_IDLE;
      q.kind <= sspr_pkg::SSPR_FK_PRM;
    end else begin
      q <= d;
    end
  end

  assign bus.fr_valid = q.fr_valid;
  assign bus.fr_sof = q.fr_sof;
  assign bus.fr_eof = q.fr_eof;
  assign bus.fr_byte = q.fr_byte;
  assign bus.fr_src = q.src;
  assign bus.fr_kind = q.kind;
  assign busy_o = q.busy;
  assign done_o = q.done;
  assign rsp_tmo_o = q.tmo;
  assign rsp_bcast_o = q.bcast;
  assign rsp_len_o = q.rlen;
  assign rsp_data_o = q.rdata;
endmodule : sspr_master
`default_nettype wire

//--- verif/sspr_props.sv
// link checks between the master and slave ends
`timescale 1ns/1ps
`default_nettype none
module sspr_props (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic fr_valid,
  input wire logic fr_sof,
  input wire logic fr_eof,
  input wire logic [6:0] fr_src,
  input wire sspr_pkg::sspr_kind_t fr_kind,
  input wire logic rs_valid,
  input wire logic rs_last,
  input wire logic rs_bcast
);
  logic infr_q;
  logic odd_q;
  sspr_pkg::sspr_kind_t kind_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      infr_q <= 1'h0;
      odd_q <= 1'h0;
      kind_q <= sspr_pkg::SSPR_FK_PRM;
    end else begin
      if (fr_valid) begin
        infr_q <= !fr_eof;
      end
      if (fr_valid && fr_eof) begin
        kind_q <= fr_kind;
      end
      // parity of answer bytes so far; words must leave whole
      if (rs_valid) begin
        odd_q <= !odd_q && !rs_last;
      end
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_ans_first;
    $rose(rs_valid);
  endsequence
  sequence s_last_byte;
    rs_valid && rs_last;
  endsequence
  a_frame_opens: assert property (fr_valid && fr_sof |-> !infr_q)
    else $error("nested frame start");
  a_frame_no_gap: assert property (fr_valid && !fr_eof |=> fr_valid)
    else $error("gap in master frame");
  a_frame_attrs_held: assert property (infr_q |-> $stable(fr_kind) && $stable(fr_src))
    else $error("frame kind changed");
  // the slave registers the end of frame, then registers its first answer byte
  a_answer_cause: assert property (s_ans_first |-> $past(fr_valid && fr_eof, 2) &&
    (kind_q == sspr_pkg::SSPR_FK_DX || kind_q == sspr_pkg::SSPR_FK_DXB))
    else $error("answer without request");
  a_answer_bcast: assert property (rs_valid |->
    rs_bcast == (kind_q == sspr_pkg::SSPR_FK_DXB)) else $error("broadcast flag wrong");
  a_answer_whole: assert property (rs_valid && !rs_last |=> rs_valid)
    else $error("answer broken off");
  a_answer_words: assert property (s_last_byte |-> odd_q)
    else $error("half word answer");
  a_answer_bound: assert property (s_ans_first |-> ##[0:15] s_last_byte)
    else $error("answer too long");
  a_quiet_line: assert property (rs_valid |-> !fr_valid)
    else $error("frame during answer");
endmodule : sspr_props
`default_nettype wire

//--- verif/fieldbus_slave_to_slave_setpoint_router_bench.sv
// bench: master and slave ends joined over the fieldbus link
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); \
  end \
end
module fieldbus_slave_to_slave_setpoint_router_bench;
  localparam int TMO = 200;
  logic clk_sys_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic req_valid = 1'h0;
  sspr_pkg::sspr_kind_t req_kind = sspr_pkg::SSPR_FK_PRM;
  logic [6:0] req_src = 7'h01;
  logic [5:0] req_len = 6'h01;
  logic [31:0][7:0] req_data = '0;
  logic [31:0][7:0] d = '0;
  logic [7:0][15:0] act = {96'h0, 16'h5678, 16'h1234};
  logic busy, done, rsp_tmo, rsp_bcast, sub, perr, cerr, lal, mal, mft;
  logic [4:0] rsp_len;
  logic [15:0][7:0] rsp_data;
  logic [7:0][15:0] sp;
  logic [2:0] lerr, lft;
  logic [7:0][7:0] dsrc, dro, dto;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // header byte index, byte value, expected bad-block flag
  logic [15:0] rows [8] = '{16'h00b1, 16'h0f51, 16'h1e31, 16'h2011, 16'h3011, 16'h4e11,
    16'h5041, 16'h00c0};
  always #12.5 clk_sys_i = ~clk_sys_i;
  sspr_bus_if bus_l (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i));
  sspr_master i_sspr_master (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus(bus_l),
    .req_valid_i(req_valid), .req_kind_i(req_kind), .req_src_i(req_src), .req_len_i(req_len),
    .req_data_i(req_data), .busy_o(busy), .done_o(done), .rsp_tmo_o(rsp_tmo),
    .rsp_bcast_o(rsp_bcast), .rsp_len_o(rsp_len), .rsp_data_o(rsp_data));
  sspr_slave #(.LINK_TMO(TMO), .MST_TMO(TMO)) i_sspr_slave (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .bus(bus_l), .act_words_i(act), .sp_words_o(sp), .subscriber_o(sub),
    .prm_err_o(perr), .cfg_err_o(cerr), .pub_len_err_o(lerr),
    .publisher_link_lost_alarm_o(lal), .publisher_link_lost_fault_o(lft),
    .master_cyclic_loss_alarm_o(mal), .master_cyclic_loss_fault_o(mft),
    .rx_word_source_address_diag_o(dsrc), .rx_word_offset_diag_o(dro),
    .tx_word_offset_diag_o(dto));
  sspr_props i_sspr_props (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .fr_valid(bus_l.fr_valid), .fr_sof(bus_l.fr_sof), .fr_eof(bus_l.fr_eof),
    .fr_src(bus_l.fr_src), .fr_kind(bus_l.fr_kind), .rs_valid(bus_l.rs_valid),
    .rs_last(bus_l.rs_last), .rs_bcast(bus_l.rs_bcast));

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // one whole request; returns once flags and diagnostics have settled
  task automatic xfer(input sspr_pkg::sspr_kind_t k, input logic [6:0] s, input logic [5:0] n);
    int t;
    t = 0;
    @(posedge clk_sys_i);
    req_kind <= k;
    req_src <= s;
    req_len <= n;
    req_data <= d;
    req_valid <= 1'h1;
    @(posedge clk_sys_i);
    req_valid <= 1'h0;
    while (done !== 1'h1 && t < 600) begin
      @(posedge clk_sys_i);
      #1;
      t++;
    end
    if (done !== 1'h1) begin
      bad_count++;
      $display("CHECK FAILED t=%0t request not finished", $time);
    end
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : xfer

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_b_i <= 1'h1;
    #1;
    `CHK(sp, 128'h0)
    `CHK(dsrc, 64'hffff_ffff_ffff_ffff)
    `CHK({sub, busy}, 2'h0)
    $display("test reset done");
    foreach (rows[i]) begin
      d = '0;
      d[11:0] = {8'h02, 8'h04, 8'h00, 8'h02, 8'h05, 8'h07, 8'h01, 8'he2, 8'h00, 8'h00,
        8'he2, 8'h0c};
      d[rows[i][15:12]] = rows[i][11:4];
      xfer(sspr_pkg::SSPR_FK_PRM, 7'h01, 6'h0c);
      `CHK(perr, rows[i][0])
      `CHK(sub, !rows[i][0])
    end
    $display("test filter header done");
    d[2:0] = {8'h00, 8'h02, 8'h02};
    xfer(sspr_pkg::SSPR_FK_CFG, 7'h01, 6'h03);
    `CHK(cerr, 1'h1)
    d[2] = sspr_pkg::CFG_TAP_ID;
    xfer(sspr_pkg::SSPR_FK_CFG, 7'h01, 6'h03);
    `CHK(cerr, 1'h0)
    d[5:0] = 48'h6655_4433_2211;
    xfer(sspr_pkg::SSPR_FK_DX, 7'h01, 6'h06);
    `CHK(sp[2:0], 48'h0000_3344_1122)
    `CHK(rsp_len, 5'h04)
    `CHK(rsp_data[3:0], 32'h7856_3412)
    `CHK(rsp_bcast, 1'h0)
    `CHK(dto[1], 8'h02)
    xfer(sspr_pkg::SSPR_FK_DXB, 7'h01, 6'h06);
    `CHK({rsp_bcast, rsp_tmo}, 2'h2)
    $display("test cyclic exchange done");
    d[1:0] = 16'hcdab;
    xfer(sspr_pkg::SSPR_FK_BCAST, 7'h05, 6'h02);
    `CHK(sp[3:2], 32'h0000_abcd)
    `CHK(dsrc[3:2], 16'hff05)
    `CHK(dro[2], 8'h04)
    d[2:0] = 24'h88_7766;
    xfer(sspr_pkg::SSPR_FK_BCAST, 7'h06, 6'h02);
    xfer(sspr_pkg::SSPR_FK_BCAST, 7'h05, 6'h03);
    `CHK(sp[2], 16'habcd)
    `CHK(lerr, 3'h1)
    $display("test publisher data done");
    `CHK({lal, mal}, 2'h0)
    repeat (TMO + 50) @(posedge clk_sys_i);
    #1;
    `CHK({lal, lft, mal, mft}, 6'h27)
    d[0] = 8'h00;
    xfer(sspr_pkg::SSPR_FK_PRM, 7'h01, 6'h01);
    d[1:0] = 16'h2211;
    xfer(sspr_pkg::SSPR_FK_BCAST, 7'h05, 6'h02);
    `CHK({sub, lft, mft}, 5'h00)
    `CHK(sp[2], 16'habcd)
    $display("test faults and plain slave done");
    // no actual words configured: the master end must give up waiting for an answer
    d[1:0] = 16'h0002;
    xfer(sspr_pkg::SSPR_FK_CFG, 7'h01, 6'h02);
    xfer(sspr_pkg::SSPR_FK_DX, 7'h01, 6'h02);
    `CHK({rsp_tmo, rsp_len}, 6'h20)
    `CHK(sp[0], 16'h0200)
    $display("test answer timeout done");
    close_out();
  end
endmodule : fieldbus_slave_to_slave_setpoint_router_bench
`default_nettype wire
